// ### adcbc_pkg.sv
// Constants and types for the converter conversion and bus control block.
// Assumes a single 250 MHz clock domain; converter clock arrives as a pin.

package adcbc_pkg;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned CONV_IN_CYC    = 20;
   localparam int unsigned CONV_INT_CYC   = CONV_IN_CYC / 2;
   localparam int unsigned HOLD_EDGE      = 3;
   localparam int unsigned ACQ_INT_CYC    = 2;
   localparam logic [3:0]  CYC_MAX        = 4'(CONV_INT_CYC);
   localparam logic [3:0]  CYC_FIRST_CMP  = 4'(ACQ_INT_CYC);
   localparam logic [1:0]  HOLD_CNT       = 2'(HOLD_EDGE);
   localparam logic [7:0]  RESULT_RST     = 8'h00;
   localparam logic [7:0]  MSB_TRIAL      = 8'h80;

   typedef enum logic [2:0] {
      ADCBC_IDLE = 3'b001,
      ADCBC_CONV = 3'b010,
      ADCBC_DONE = 3'b100
   } adcbc_state_t;

   typedef struct packed {
      logic [7:0] q;
      logic       oe;
   } adcbc_bus_t;
endpackage

// ### adcbc_core.sv
// Conversion control and bus side of an 8-bit successive-approximation converter.
// Assumes pins arrive asynchronous; comparator output is a pin from the analog side.
`timescale 1ns/100ps
`default_nettype none

module adcbc_core (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              select_n,
   input  wire logic              read_n,
   input  wire logic              conv_clk,
   input  wire logic              comp_high,
   output logic                   busy_n,
   output logic                   hold,
   output logic [7:0]             trial_code,
   output adcbc_pkg::adcbc_bus_t  data_bus
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] sel_s_q, sel_s_d, rd_s_q, rd_s_d, ck_s_q, ck_s_d, cmp_s_q, cmp_s_d;
   logic       ck_last_q, ck_last_d;
   // Unreset: a reset of three cycles or more flushes them
   always_comb begin
      sel_s_d   = {sel_s_q[0], select_n};
      rd_s_d    = {rd_s_q[0], read_n};
      ck_s_d    = {ck_s_q[0], conv_clk};
      cmp_s_d   = {cmp_s_q[0], comp_high};
      ck_last_d = ck_s_q[1];
   end

   always_ff @(posedge clk) begin
      sel_s_q   <= sel_s_d;
      rd_s_q    <= rd_s_d;
      ck_s_q    <= ck_s_d;
      cmp_s_q   <= cmp_s_d;
      ck_last_q <= ck_last_d;
   end

   logic access, fall;
   assign access = ~sel_s_q[1] & ~rd_s_q[1];
   assign fall   = ck_last_q & ~ck_s_q[1];

   // ----------------------------------------
   // Control state
   // ----------------------------------------
   adcbc_pkg::adcbc_state_t st_q, st_d;
   logic       acc_q, acc_d, half_q, half_d, hold_q, hold_d;
   logic [1:0] fcnt_q, fcnt_d;
   logic [3:0] cyc_q, cyc_d;
   logic [7:0] sar_q, sar_d, bit_q, bit_d, out_q, out_d;
   logic       start;
   logic       int_tick;

   // Level edge of access so a held read starts only once
   assign start    = access & ~acc_q;
   assign int_tick = fall & half_q;

   always_comb begin
      st_d   = st_q;
      acc_d  = access;
      half_d = half_q;
      hold_d = hold_q;
      fcnt_d = fcnt_q;
      cyc_d  = cyc_q;
      sar_d  = sar_q;
      bit_d  = bit_q;
      out_d  = out_q;
      case (st_q)
         adcbc_pkg::ADCBC_IDLE: begin
            hold_d = 1'b0;
            if (start) begin
               st_d   = adcbc_pkg::ADCBC_CONV;
               half_d = 1'b0;
               fcnt_d = 2'd0;
               cyc_d  = 4'd0;
            end
         end
         adcbc_pkg::ADCBC_CONV: begin
            if (fall) begin
               half_d = ~half_q;
               if (fcnt_q != adcbc_pkg::HOLD_CNT) begin
                  fcnt_d = fcnt_q + 2'd1;
                  if (fcnt_q + 2'd1 == adcbc_pkg::HOLD_CNT) begin
                     hold_d = 1'b1;
                  end
               end
            end
            if (int_tick) begin
               cyc_d = cyc_q + 4'd1;
               if (cyc_q == 4'd0) begin
                  sar_d = adcbc_pkg::MSB_TRIAL;
                  bit_d = adcbc_pkg::MSB_TRIAL;
               end else if (cyc_q >= adcbc_pkg::CYC_FIRST_CMP) begin
                  // Keep trial bit when input beats trial level
                  sar_d = (cmp_s_q[1] ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
                  bit_d = bit_q >> 1;
               end
               if (cyc_q + 4'd1 == adcbc_pkg::CYC_MAX) begin
                  st_d  = adcbc_pkg::ADCBC_DONE;
                  out_d = sar_d;
                  half_d = 1'b0;
               end
            end
         end
         adcbc_pkg::ADCBC_DONE: begin
            hold_d = 1'b0;
            // One converter clock of grace: a read here only fetches data
            if (fall) begin
               st_d = adcbc_pkg::ADCBC_IDLE;
            end else if (start) begin
               st_d = adcbc_pkg::ADCBC_DONE;
            end
         end
         default: st_d = adcbc_pkg::ADCBC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q   <= adcbc_pkg::ADCBC_IDLE;
         acc_q  <= 1'b0;
         half_q <= 1'b0;
         hold_q <= 1'b0;
         fcnt_q <= 2'd0;
         cyc_q  <= 4'd0;
         sar_q  <= adcbc_pkg::RESULT_RST;
         bit_q  <= adcbc_pkg::RESULT_RST;
         out_q  <= adcbc_pkg::RESULT_RST;
      end else begin
         st_q   <= st_d;
         acc_q  <= acc_d;
         half_q <= half_d;
         hold_q <= hold_d;
         fcnt_q <= fcnt_d;
         cyc_q  <= cyc_d;
         sar_q  <= sar_d;
         bit_q  <= bit_d;
         out_q  <= out_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Reads mid-conversion see the old latch; the hold may be disturbed
   assign busy_n      = (st_q != adcbc_pkg::ADCBC_CONV);
   assign hold        = hold_q;
   assign trial_code  = sar_q;
   // One driver for the whole carrier; q is the latch, oe the live access
   assign data_bus    = '{q: out_q, oe: access};

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   // Counts converter falls apart from the tick logic, saturating
   logic [4:0] fall_seen_q, fall_seen_d;
   always_comb begin
      fall_seen_d = fall_seen_q;
      if (st_q == adcbc_pkg::ADCBC_IDLE && start) begin
         fall_seen_d = 5'h00;
      end else if (!busy_n && fall && fall_seen_q != 5'h1f) begin
         fall_seen_d = fall_seen_q + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fall_seen_q <= 5'h00;
      end else begin
         fall_seen_q <= fall_seen_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_start_taken;
      st_q == adcbc_pkg::ADCBC_IDLE && start;
   endsequence
   sequence s_conv_ends;
      $rose(busy_n);
   endsequence

   chk_busy_on_start: assert property (@(posedge clk) disable iff (reset)
      s_start_taken |=> !busy_n)
      else $error("busy_n not low after start");
   chk_latch_on_done: assert property (@(posedge clk) disable iff (reset)
      s_conv_ends |-> out_q == $past(sar_d))
      else $error("latch not loaded at busy rise");
   chk_latch_holds: assert property (@(posedge clk) disable iff (reset)
      (busy_n && $past(busy_n)) |-> $stable(out_q))
      else $error("latch changed while idle");
   chk_oe_access: assert property (@(posedge clk) disable iff (reset)
      data_bus.oe == (!$past(select_n, 2) && !$past(read_n, 2)))
      else $error("data drive outside access");
   chk_hold_third: assert property (@(posedge clk) disable iff (reset)
      $rose(hold_q) |-> $past(fcnt_q) == 2'd2 && $past(fall))
      else $error("hold not on third falling edge");
   chk_cycle_count: assert property (@(posedge clk) disable iff (reset)
      $rose(busy_n) |-> $past(cyc_q) == adcbc_pkg::CYC_MAX - 4'd1)
      else $error("conversion length wrong");
   chk_sar_clear: assert property (@(posedge clk) disable iff (reset)
      (busy_n == 1'b0 && int_tick && cyc_q == 4'd0) |=> sar_q == adcbc_pkg::MSB_TRIAL)
      else $error("approximation register not cleared");
   chk_grace_nostart: assert property (@(posedge clk) disable iff (reset)
      (st_q == adcbc_pkg::ADCBC_DONE && !fall) |=> busy_n)
      else $error("start during grace period");
   chk_conv_falls: assert property (@(posedge clk) disable iff (reset)
      s_conv_ends |-> fall_seen_q == 5'(adcbc_pkg::CONV_IN_CYC))
      else $error("conversion not twenty converter clocks");
   chk_clock_halt: assert property (@(posedge clk) disable iff (reset)
      busy_n |=> $stable(sar_q))
      else $error("approximation moved while idle");
   chk_acq_window: assert property (@(posedge clk) disable iff (reset)
      (int_tick && cyc_q == 4'h1) |=> sar_q == adcbc_pkg::MSB_TRIAL)
      else $error("decision made during acquisition");
   chk_hold_release: assert property (@(posedge clk) disable iff (reset)
      s_conv_ends |=> !hold_q)
      else $error("input not tracking after conversion");
   chk_mid_read: assert property (@(posedge clk) disable iff (reset)
      (!busy_n && start && !int_tick) |=> $stable(out_q))
      else $error("mid conversion read disturbed latch");

endmodule
`default_nettype wire

// ### adcbc_analog_model.sv
// Analog side stand-in: free converter clock and comparator.
// Assumes the core drives trial_code and hold.
`timescale 1ns/100ps
`default_nettype none
module adcbc_analog_model (
   input  wire logic [8:0] ain_x2,
   input  wire logic       hold,
   input  wire logic [7:0] trial_code,
   output logic            conv_clk,
   output logic            comp_high
);
   logic [8:0] held;
   // Runs free; the core must gate its own clock
   // Offset keeps converter edges off the system clock edges
   initial begin
      conv_clk = 1'b0;
      #1;
      forever #20 conv_clk = ~conv_clk;
   end
   always @(posedge hold) held = ain_x2;
   // Half-LSB input; threshold half an LSB under each code
   assign comp_high = ({1'b0, hold ? held : ain_x2} + 10'h001) >= {1'b0, trial_code, 1'b0};
endmodule
`default_nettype wire

// ### test_adc_conversion_bus_control.sv
// Self-checking bench for the conversion control core.
// Assumes the analog model supplies conv_clk and comp_high.
`timescale 1ns/100ps
`default_nettype none
module test_adc_conversion_bus_control;
   logic                  clk, reset, select_n, read_n, conv_clk, comp_high, busy_n, hold;
   logic [7:0]            trial_code, prev;
   logic [8:0]            ain_x2;
   adcbc_pkg::adcbc_bus_t data_bus;
   int                    errors, checks, falls, start_at, hold_at, busy_at, k;
   logic [8:0]            vals [4] = '{9'h000, 9'h003, 9'h1ff, 9'h12c};
   logic [7:0]            codes [4] = '{8'h00, 8'h02, 8'hff, 8'h96};

   adcbc_core adcbc_core_inst (.clk(clk), .reset(reset), .select_n(select_n),
      .read_n(read_n), .conv_clk(conv_clk), .comp_high(comp_high), .busy_n(busy_n),
      .hold(hold), .trial_code(trial_code), .data_bus(data_bus));
   adcbc_analog_model adcbc_analog_model_inst (.ain_x2(ain_x2), .hold(hold),
      .trial_code(trial_code), .conv_clk(conv_clk), .comp_high(comp_high));

   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(negedge conv_clk) falls++;
   always @(negedge select_n) if (busy_n === 1'b1) start_at = falls;
   always @(posedge hold) hold_at = falls;
   always @(posedge busy_n) busy_at = falls;

   task cmp(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task stop_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task wait_busy;
      for (k = 0; k < 400 && busy_n !== 1'b1; k++) @(negedge clk);
   endtask

   // Pins fall together and stay low until the data is taken
   task rd(input logic [7:0] want, input logic busy_want, input logic stall);
      @(negedge clk);
      select_n = 1'b0;
      read_n = 1'b0;
      repeat (4) @(negedge clk);
      cmp(busy_n, busy_want);
      if (stall) wait_busy();
      @(negedge clk);
      cmp(data_bus.oe, 1'b1);
      cmp(data_bus.q, want);
      select_n = 1'b1;
      read_n = 1'b1;
      repeat (3) @(negedge clk);
      cmp(data_bus.oe, 1'b0);
   endtask

   initial begin
      reset = 1'b1;
      select_n = 1'b1;
      read_n = 1'b1;
      ain_x2 = 9'h000;
      prev = 8'h00;
      repeat (8) @(negedge clk);
      cmp(busy_n, 1'b1);
      cmp(hold, 1'b0);
      cmp(data_bus.q, 8'h00);
      reset = 1'b0;
      for (int i = 0; i < 4; i++) begin
         ain_x2 = vals[i];
         @(negedge conv_clk);
         rd(prev, 1'b0, 1'b0);
         repeat (40) @(negedge clk);
         // A mid-run read may spoil this result, so only the last one does it
         if (i == 3) rd(prev, 1'b0, 1'b0);
         wait_busy();
         cmp(8'(hold_at - start_at), 8'h03);
         cmp(8'(busy_at - start_at), 8'h14);
         prev = codes[i];
         if (i >= 2) rd(prev, 1'b1, 1'b0);
         repeat (2) @(negedge conv_clk);
      end
      ain_x2 = vals[1];
      @(negedge conv_clk);
      rd(codes[1], 1'b0, 1'b1);
      stop_test();
   end

   // About seventeen times the expected run
   initial begin
      #80000;
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
